// ---- src/hbg_gate_top.sv ----
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module hbg_gate_top
   import hbg_pkg::*;
#(
   parameter int SINK_LEN = SINK_CYCLES
)
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // register port
   input  wire logic [ADDR_W-1:0]  addr,
   input  wire logic [DATA_W-1:0]  wrData,
   input  wire logic               wrStrobe,
   input  wire logic               rdStrobe,
   output logic [DATA_W-1:0]       rdData,
   // bridge pwm pins
   input  wire logic               pwmA1,
   input  wire logic               pwmA2,
   input  wire logic               pwmB1,
   input  wire logic               pwmB2,
   // fault flags
   input  wire logic               cpLow,
   input  wire logic               overVolt,
   input  wire logic               thermal,
   input  wire logic [3:0]         dsShortA,
   input  wire logic [3:0]         dsShortB,
   // watchdog
   input  wire logic               wdLongOpen,
   input  wire logic               wdTrigValid,
   // gate commands
   output hbg_bridge_type          gatesA,
   output hbg_bridge_type          gatesB,
   output logic                    forceOff
);

   hbg_pins_type        pinRaw;
   hbg_pins_type        pinMeta_reg;
   hbg_pins_type        pinSync_reg;
   hbg_ctrl_type        ctrlA_reg;
   hbg_ctrl_type        ctrlA_next;
   hbg_ctrl_type        ctrlB_reg;
   hbg_ctrl_type        ctrlB_next;
   logic [DATA_W-1:0]   rdData_reg;
   logic [DATA_W-1:0]   rdData_next;
   logic                forceOff_reg;
   logic                forceOff_next;
   hbg_bridge_in_type   inA;
   hbg_bridge_in_type   inB;
   logic                sinkA;
   logic                sinkB;

   assign pinRaw = '{pwmA1, pwmA2, pwmB1, pwmB2, cpLow, overVolt, thermal,
                     hbg_short_type'(dsShortA), hbg_short_type'(dsShortB)};

   ////////////////////////////////////////////////////////////////////////////////////
   // pins are asynchronous; first stage feeds only the second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
      end else begin
         pinMeta_reg <= pinRaw;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // two-cycle sync fits pulses longer than 250 ns
   assign inA = '{pinSync_reg.pwmA1, pinSync_reg.pwmA2, pinSync_reg.cpLow,
                  pinSync_reg.overVolt, pinSync_reg.thermal, pinSync_reg.shortA};
   assign inB = '{pinSync_reg.pwmB1, pinSync_reg.pwmB2, pinSync_reg.cpLow,
                  pinSync_reg.overVolt, pinSync_reg.thermal, pinSync_reg.shortB};

   ////////////////////////////////////////////////////////////////////////////////////
   // watchdog hold: long window sets, valid trigger outside it clears
   always_comb begin
      forceOff_next = forceOff_reg;
      if (wdLongOpen) begin
         forceOff_next = 1'b1;
      end else if (wdTrigValid) begin
         forceOff_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         forceOff_reg <= 1'b0;
      end else begin
         forceOff_reg <= forceOff_next;
      end
   end

   assign forceOff = forceOff_reg;

   ////////////////////////////////////////////////////////////////////////////////////
   // register port, never gated by the watchdog hold
   always_comb begin
      ctrlA_next  = ctrlA_reg;
      ctrlB_next  = ctrlB_reg;
      rdData_next = '0;
      if (wrStrobe) begin
         case (addr)
            REG_CTRL_A: ctrlA_next = hbg_ctrl_type'(wrData & CTRL_MASK);
            REG_CTRL_B: ctrlB_next = hbg_ctrl_type'(wrData & CTRL_MASK);
            default: ;
         endcase
      end
      if (rdStrobe) begin
         case (addr)
            REG_CTRL_A: rdData_next = ctrlA_reg;
            REG_CTRL_B: rdData_next = ctrlB_reg;
            REG_STATUS: begin
               rdData_next[STAT_FORCE_BIT]  = forceOff_reg;
               rdData_next[STAT_SINK_A_BIT] = sinkA;
               rdData_next[STAT_SINK_B_BIT] = sinkB;
               rdData_next[STAT_CP_BIT]     = pinSync_reg.cpLow;
               rdData_next[STAT_OV_BIT]     = pinSync_reg.overVolt;
               rdData_next[STAT_TSD_BIT]    = pinSync_reg.thermal;
            end
            default: rdData_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlA_reg  <= hbg_ctrl_type'(CTRL_RESET);
         ctrlB_reg  <= hbg_ctrl_type'(CTRL_RESET);
         rdData_reg <= '0;
      end else begin
         ctrlA_reg  <= ctrlA_next;
         ctrlB_reg  <= ctrlB_next;
         rdData_reg <= rdData_next;
      end
   end

   assign rdData = rdData_reg;

   ////////////////////////////////////////////////////////////////////////////////////
   hbg_bridge_ctrl #(
      .SINK_LEN   (SINK_LEN)
   ) bridgeA (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .ctrl       (ctrlA_reg),
      .pins       (inA),
      .forceOff   (forceOff_reg),
      .gates      (gatesA),
      .sinkActive (sinkA)
   );

   hbg_bridge_ctrl #(
      .SINK_LEN   (SINK_LEN)
   ) bridgeB (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .ctrl       (ctrlB_reg),
      .pins       (inB),
      .forceOff   (forceOff_reg),
      .gates      (gatesB),
      .sinkActive (sinkB)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic cleanA;
   logic faultFree;

   assign faultFree = !pinSync_reg.cpLow && !pinSync_reg.overVolt && !pinSync_reg.thermal;
   assign cleanA    = ctrlA_reg.enable && !ctrlA_reg.dualMode && !forceOff_reg && faultFree
                      && pinSync_reg.shortA == '0;

   singleDrive_a: assert property (
      (cleanA && pinSync_reg.pwmA1 && !ctrlA_reg.direction) |=>
      (gatesA.hs2 == GATE_HIGH && gatesA.ls1 == GATE_HIGH
       && gatesA.hs1 == GATE_LOW && gatesA.ls2 == GATE_LOW))
      else $error("single mode diagonal drive wrong");

   lowActiveFw_a: assert property (
      (cleanA && !pinSync_reg.pwmA1 && !ctrlA_reg.side1 && !ctrlA_reg.passive1) |=>
      (gatesA.ls1 == GATE_HIGH && gatesA.ls2 == GATE_HIGH
       && gatesA.hs1 == GATE_LOW && gatesA.hs2 == GATE_LOW))
      else $error("active low side freewheel wrong");

   highActiveFw_a: assert property (
      (cleanA && !pinSync_reg.pwmA1 && ctrlA_reg.side1 && !ctrlA_reg.passive1) |=>
      (gatesA.hs1 == GATE_HIGH && gatesA.hs2 == GATE_HIGH
       && gatesA.ls1 == GATE_LOW && gatesA.ls2 == GATE_LOW))
      else $error("active high side freewheel wrong");

   lowPassiveFw_a: assert property (
      (cleanA && !pinSync_reg.pwmA1 && !ctrlA_reg.side1 && ctrlA_reg.passive1) |=>
      (gatesA.ls1 == ($past(ctrlA_reg.direction) ? GATE_LOW : GATE_HIGH)
       && gatesA.ls2 == ($past(ctrlA_reg.direction) ? GATE_HIGH : GATE_LOW)
       && gatesA.hs1 == GATE_LOW && gatesA.hs2 == GATE_LOW))
      else $error("passive low side freewheel wrong");

   disabledRl_a: assert property (
      (!ctrlB_reg.enable && !forceOff_reg) ##1 (!ctrlB_reg.enable && !forceOff_reg) |->
      (gatesB.hs1 == GATE_RLOW && gatesB.ls2 == GATE_RLOW))
      else $error("disabled bridge not resistive low");

   overVoltLow_a: assert property (
      (ctrlA_reg.enable && !forceOff_reg && pinSync_reg.overVolt && !pinSync_reg.cpLow
       && !pinSync_reg.thermal) |=> (gatesA.hs1 == GATE_LOW && gatesA.ls1 == GATE_LOW
       && gatesA.hs2 == GATE_LOW && gatesA.ls2 == GATE_LOW))
      else $error("overvoltage did not drive low");

   shortHalf_a: assert property (
      (ctrlA_reg.enable && !ctrlA_reg.dualMode && !forceOff_reg && faultFree
       && pinSync_reg.shortA == 4'h8 && pinSync_reg.pwmA1 && ctrlA_reg.direction) |=>
      (gatesA.hs1 == GATE_LOW && gatesA.ls1 == GATE_LOW && gatesA.ls2 == GATE_HIGH))
      else $error("short did not isolate one half bridge");

   dualLeg_a: assert property (
      (ctrlA_reg.enable && ctrlA_reg.dualMode && !forceOff_reg && faultFree
       && pinSync_reg.shortA == '0 && pinSync_reg.pwmA2 && ctrlA_reg.side2) |=>
      (gatesA.hs2 == GATE_LOW && gatesA.ls2 == GATE_HIGH))
      else $error("dual leg two swapped drive wrong");

   sinkFirst_a: assert property (
      ($rose(pinSync_reg.thermal) && ctrlA_reg.enable && !forceOff_reg
       && !pinSync_reg.cpLow) |=> (gatesA.hs1 == GATE_LOW && sinkA))
      else $error("failure skipped the sink phase");

   wdForce_a: assert property (
      wdLongOpen |=> forceOff_reg ##1 (gatesA.hs1 == GATE_LOW && gatesB.ls2 == GATE_LOW))
      else $error("long open window did not force drivers off");

   wdHold_a: assert property (
      (forceOff_reg && !wdLongOpen && !wdTrigValid) |=> forceOff_reg)
      else $error("watchdog hold released without trigger");

   regRead_a: assert property (
      (rdStrobe && addr == REG_CTRL_A) |=> rdData == $past(ctrlA_reg))
      else $error("control register read wrong");

   coverSingle: cover property (cleanA && pinSync_reg.pwmA1 ##1 !pinSync_reg.pwmA1);
   coverDual: cover property (ctrlB_reg.dualMode && ctrlB_reg.enable && pinSync_reg.pwmB2);
   coverSink: cover property (sinkA ##1 !sinkA);
   coverWdWrite: cover property (forceOff_reg && wrStrobe ##1 forceOff_reg && rdStrobe);

endmodule

// ---- src/hbg_pkg.sv ----
// Contract
// - Single mode: direction from direction bit, duty and frequency from first PWM.
// - Single, PWM high: dir 0 gives HS2+LS1, dir 1 gives HS1+LS2.
// - Single, PWM low: side and passive selects pick one of four freewheel modes.
// - PWM low, both selects 0: both low sides on, high sides off.
// - PWM low, high side active: both high sides on, low sides off.
// - PWM low, low side passive: LS1 on for dir 0, LS2 for dir 1.
// - PWM low, high side passive: HS2 on for dir 0, HS1 for dir 1.
// - Disabled, charge pump low or thermal gives resistive low; overvoltage drives low.
// - Drain-source short turns off only the affected half bridge.
// - Dual mode: each leg runs from its own PWM input and selects.
// - Dual leg: side 0 drives high gate on PWM, side 1 swaps gates.
// - Watchdog long open window forces drivers off until a valid trigger.
// - Control registers stay readable and writable during the long open window.
// - Failure entry to resistive low first sinks for 32 to 64 us; a sink missed or cut by the watchdog hold is not redone after release.
package hbg_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int SINK_TIME_NS  = 32000;
   localparam int SINK_CYCLES   = (SINK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SINK_CNT_W    = 10;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] REG_CTRL_A = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CTRL_B = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_MASK  = 8'h7f;

   localparam int STAT_FORCE_BIT  = 0;
   localparam int STAT_SINK_A_BIT = 1;
   localparam int STAT_SINK_B_BIT = 2;
   localparam int STAT_CP_BIT     = 3;
   localparam int STAT_OV_BIT     = 4;
   localparam int STAT_TSD_BIT    = 5;

   typedef enum logic [1:0] {GATE_LOW, GATE_HIGH, GATE_RLOW} hbg_gate_type;

   typedef struct packed {
      hbg_gate_type hs1;
      hbg_gate_type ls1;
      hbg_gate_type hs2;
      hbg_gate_type ls2;
   } hbg_bridge_type;

   // bit 0 is enable, bit 7 spare
   typedef struct packed {
      logic spare;
      logic passive2;
      logic side2;
      logic passive1;
      logic side1;
      logic dualMode;
      logic direction;
      logic enable;
   } hbg_ctrl_type;

   typedef struct packed {
      logic hs1;
      logic ls1;
      logic hs2;
      logic ls2;
   } hbg_short_type;

   typedef struct packed {
      logic          pwm1;
      logic          pwm2;
      logic          cpLow;
      logic          overVolt;
      logic          thermal;
      hbg_short_type dsShort;
   } hbg_bridge_in_type;

   typedef struct packed {
      logic          pwmA1;
      logic          pwmA2;
      logic          pwmB1;
      logic          pwmB2;
      logic          cpLow;
      logic          overVolt;
      logic          thermal;
      hbg_short_type shortA;
      hbg_short_type shortB;
   } hbg_pins_type;

endpackage

// ---- src/hbg_bridge_ctrl.sv ----
`timescale 1ns/1ns
module hbg_bridge_ctrl
   import hbg_pkg::*;
#(
   parameter int SINK_LEN = SINK_CYCLES
)
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // control
   input  wire hbg_ctrl_type       ctrl,
   input  wire hbg_bridge_in_type  pins,
   input  wire logic               forceOff,
   // gate commands
   output hbg_bridge_type          gates,
   output logic                    sinkActive
);

   hbg_bridge_type          gates_reg;
   hbg_bridge_type          gates_next;
   logic                    sink_reg;
   logic                    sink_next;
   logic                    failPrev_reg;
   logic                    failPrev_next;
   logic [SINK_CNT_W-1:0]   sinkCnt_reg;
   logic [SINK_CNT_W-1:0]   sinkCnt_next;
   logic                    failRl;
   logic [3:0]              on;
   logic [1:0]              leg1;
   logic [1:0]              leg2;

   function automatic hbg_gate_type toGate(input logic drive);
      return drive ? GATE_HIGH : GATE_LOW;
   endfunction

   // returns {high gate, low gate}
   function automatic logic [1:0] legOn(input logic pwm, input logic side, input logic passive);
      if (pwm) begin
         return side ? 2'b01 : 2'b10;
      end else if (passive) begin
         return 2'b00;
      end
      return side ? 2'b10 : 2'b01;
   endfunction

   assign gates      = gates_reg;
   assign sinkActive = sink_reg;

   ////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      failRl        = ctrl.enable && (pins.cpLow || pins.thermal);
      failPrev_next = failRl;
      sinkCnt_next  = '0;
      sink_next     = 1'b0;
      leg1          = legOn(pins.pwm1, ctrl.side1, ctrl.passive1);
      leg2          = legOn(pins.pwm2, ctrl.side2, ctrl.passive2);
      // on bits ordered hs1, ls1, hs2, ls2
      if (!ctrl.dualMode) begin
         if (pins.pwm1) begin
            on = ctrl.direction ? 4'b1001 : 4'b0110;
         end else begin
            case ({ctrl.side1, ctrl.passive1})
               2'b00: on = 4'b0101;
               2'b10: on = 4'b1010;
               2'b01: on = ctrl.direction ? 4'b0001 : 4'b0100;
               default: on = ctrl.direction ? 4'b1000 : 4'b0010;
            endcase
         end
      end else begin
         on = {leg1, leg2};
      end
      if (pins.dsShort.hs1 || pins.dsShort.ls1) begin
         on[3:2] = 2'b00;
      end
      if (pins.dsShort.hs2 || pins.dsShort.ls2) begin
         on[1:0] = 2'b00;
      end
      gates_next = '{toGate(on[3]), toGate(on[2]), toGate(on[1]), toGate(on[0])};
      if (forceOff) begin
         gates_next = '{GATE_LOW, GATE_LOW, GATE_LOW, GATE_LOW};
      end else if (!ctrl.enable) begin
         gates_next = '{GATE_RLOW, GATE_RLOW, GATE_RLOW, GATE_RLOW};
      end else if (failRl) begin
         if (!failPrev_reg) begin
            gates_next   = '{GATE_LOW, GATE_LOW, GATE_LOW, GATE_LOW};
            sinkCnt_next = SINK_CNT_W'(SINK_LEN - 1);
            sink_next    = 1'b1;
         end else if (sinkCnt_reg != '0) begin
            gates_next   = '{GATE_LOW, GATE_LOW, GATE_LOW, GATE_LOW};
            sinkCnt_next = sinkCnt_reg - 1'b1;
            sink_next    = 1'b1;
         end else begin
            gates_next = '{GATE_RLOW, GATE_RLOW, GATE_RLOW, GATE_RLOW};
         end
      end else if (pins.overVolt) begin
         gates_next = '{GATE_LOW, GATE_LOW, GATE_LOW, GATE_LOW};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gates_reg    <= '{GATE_RLOW, GATE_RLOW, GATE_RLOW, GATE_RLOW};
         sink_reg     <= 1'b0;
         failPrev_reg <= 1'b0;
         sinkCnt_reg  <= '0;
      end else begin
         gates_reg    <= gates_next;
         sink_reg     <= sink_next;
         failPrev_reg <= failPrev_next;
         sinkCnt_reg  <= sinkCnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   sinkBound_a: assert property (
      @(posedge clk_sys) disable iff (rst) sinkCnt_reg < SINK_CNT_W'(SINK_LEN))
      else $error("sink counter above its length");

   sinkThenRl_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (failRl && failPrev_reg && sinkCnt_reg == '0 && !forceOff) |=> gates_reg.ls2 == GATE_RLOW)
      else $error("no resistive low after sink phase");

endmodule

// ---- testbench/hbg_mcu_model.sv ----
`timescale 1ns/1ns
module hbg_mcu_model
#(
   parameter int MIN_HIGH = 7
)
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // levels asked for by the bench, bit 3 first pin of bridge a
   input  wire logic [3:0] pwmReq,
   // pwm pins toward the device
   output logic [3:0]      pwmPin
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0]      pwmNext;
   logic [3:0][3:0] holdReg;
   logic [3:0][3:0] holdNext;

   // high phase kept long
   // a short request is stretched, never dropped, so duty may grow a little
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pwmNext[i] = pwmReq[i] | (pwmPin[i] & (holdReg[i] < 4'(MIN_HIGH - 1)));
         holdNext[i] = 4'h0;
         if (pwmNext[i] && pwmPin[i]) begin
            holdNext[i] = (holdReg[i] == 4'hf) ? holdReg[i] : holdReg[i] + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwmPin <= 4'h0;
         holdReg <= '0;
      end else begin
         pwmPin <= pwmNext;
         holdReg <= holdNext;
      end
   end
endmodule

// ---- testbench/hbg_gate_top_tb.sv ----
`timescale 1ns/1ns
module hbg_gate_top_tb
   import hbg_pkg::*;
;
   // short sink phase keeps the run brief
   localparam int SINK = 8;
   localparam logic [7:0] ALL_RL = {4{GATE_RLOW}};

   logic              clk_sys, rst, wrStrobe, rdStrobe, forceOff;
   logic              cpLow, overVolt, thermal, wdLongOpen, wdTrigValid;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData, rdData;
   logic [3:0]        dsShortA, dsShortB, pwmReq, pwmPin;
   hbg_bridge_type    gatesA, gatesB;
   int                bad_count = 0;
   int                check_count = 0;

   hbg_gate_top #(.SINK_LEN(SINK)) uut (
      .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .rdData(rdData), .pwmA1(pwmPin[3]), .pwmA2(pwmPin[2]),
      .pwmB1(pwmPin[1]), .pwmB2(pwmPin[0]), .cpLow(cpLow), .overVolt(overVolt),
      .thermal(thermal), .dsShortA(dsShortA), .dsShortB(dsShortB),
      .wdLongOpen(wdLongOpen), .wdTrigValid(wdTrigValid), .gatesA(gatesA),
      .gatesB(gatesB), .forceOff(forceOff));

   hbg_mcu_model mcu (.clk_sys(clk_sys), .rst(rst), .pwmReq(pwmReq), .pwmPin(pwmPin));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wrStrobe <= 1'b1;
      addr <= a;
      wrData <= d;
      @(posedge clk_sys);
      wrStrobe <= 1'b0;
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys);
      rdStrobe <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      #1;
      chk(rdData, exp, what);
   endtask

   task automatic pulse_watchdog_trigger_bit();
      @(posedge clk_sys);
      wdTrigValid <= 1'b1;
      @(posedge clk_sys);
      wdTrigValid <= 1'b0;
   endtask

   function automatic hbg_bridge_type on4(input logic [3:0] m);
      hbg_bridge_type b;
      b.hs1 = m[3] ? GATE_HIGH : GATE_LOW;
      b.ls1 = m[2] ? GATE_HIGH : GATE_LOW;
      b.hs2 = m[1] ? GATE_HIGH : GATE_LOW;
      b.ls2 = m[0] ? GATE_HIGH : GATE_LOW;
      return b;
   endfunction

   // on-mask {hs1,ls1,hs2,ls2} of a bridge in single mode
   function automatic logic [3:0] expS(input logic p, input logic d, input logic s,
                                       input logic q);
      if (p) return d ? 4'b1001 : 4'b0110;
      case ({s, q})
         2'b00: return 4'b0101;
         2'b10: return 4'b1010;
         2'b01: return d ? 4'b0001 : 4'b0100;
         default: return d ? 4'b1000 : 4'b0010;
      endcase
   endfunction

   // on-mask {high,low} of one leg in dual mode
   function automatic logic [1:0] leg(input logic p, input logic s, input logic q);
      if (p) return s ? 2'b01 : 2'b10;
      if (q) return 2'b00;
      return s ? 2'b10 : 2'b01;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(gatesA, ALL_RL, "reset gates a");
      chk(gatesB, ALL_RL, "reset gates b");
      chk(8'(forceOff), 8'h00, "reset hold");
      rdchk(REG_CTRL_A, CTRL_RESET, "ctrl a reset");
      rdchk(REG_CTRL_B, CTRL_RESET, "ctrl b reset");
      wr(REG_CTRL_A, 8'hff);
      rdchk(REG_CTRL_A, CTRL_MASK, "ctrl a spare bit");
      wr(REG_STATUS, 8'hff);
      rdchk(REG_STATUS, 8'h00, "status read only");
      rdchk(4'h2, 8'h00, "unmapped read");
      wr(REG_CTRL_A, 8'h00);
      cyc(3);
      chk(gatesA, ALL_RL, "disabled bridge");
   endtask

   task automatic t_single();
      for (int i = 0; i < 16; i++) begin
         automatic logic [3:0] v = 4'(i);
         wr(REG_CTRL_A, {3'b000, v[0], v[1], 1'b0, v[2], 1'b1});
         wr(REG_CTRL_B, {3'b000, v[0], v[1], 1'b0, v[2], 1'b1});
         pwmReq <= {v[3], ~v[3], v[3], ~v[3]};
         cyc(6);
         chk(gatesA, on4(expS(v[3], v[2], v[1], v[0])), "single a");
         chk(gatesB, on4(expS(v[3], v[2], v[1], v[0])), "single b");
      end
   endtask

   task automatic t_dual();
      for (int i = 0; i < 8; i++) begin
         automatic logic [2:0] v = 3'(i);
         automatic logic [2:0] w = ~v;
         wr(REG_CTRL_A, {1'b0, w[0], w[1], v[0], v[1], 3'b101});
         wr(REG_CTRL_B, {1'b0, w[0], w[1], v[0], v[1], 3'b101});
         pwmReq <= {v[2], w[2], v[2], w[2]};
         cyc(6);
         chk(gatesA, on4({leg(v[2], v[1], v[0]), leg(w[2], w[1], w[0])}), "dual a");
         chk(gatesB, on4({leg(v[2], v[1], v[0]), leg(w[2], w[1], w[0])}), "dual b");
      end
   endtask

   task automatic t_short();
      wr(REG_CTRL_A, 8'h03);
      wr(REG_CTRL_B, 8'h03);
      pwmReq <= 4'b1010;
      @(posedge clk_sys);
      dsShortA <= 4'b1000;
      dsShortB <= 4'b0001;
      cyc(6);
      chk(gatesA, on4(4'b0001), "short first half");
      chk(gatesB, on4(4'b1000), "short second half");
      @(posedge clk_sys);
      dsShortA <= 4'h0;
      dsShortB <= 4'h0;
      cyc(6);
      chk(gatesA, on4(4'b1001), "short cleared");
   endtask

   task automatic t_fault();
      for (int f = 0; f < 3; f++) begin
         wr(REG_CTRL_B, 8'h00);
         wr(REG_CTRL_A, 8'h03);
         pwmReq <= 4'b1000;
         cyc(6);
         chk(gatesA, on4(4'b1001), "before fault");
         @(posedge clk_sys);
         thermal <= (f == 0);
         cpLow <= (f == 1);
         overVolt <= (f == 2);
         cyc(6);
         chk(gatesA, 8'h00, "fault sink");
         rdchk(REG_STATUS, (f == 2) ? 8'h01 << STAT_OV_BIT : (8'h01 << STAT_SINK_A_BIT) |
               (8'h01 << ((f == 0) ? STAT_TSD_BIT : STAT_CP_BIT)), "fault status");
         cyc(10);
         chk(gatesA, (f == 2) ? 8'h00 : ALL_RL, "fault settled");
         chk(gatesB, ALL_RL, "disabled in fault");
         @(posedge clk_sys);
         thermal <= 1'b0;
         cpLow <= 1'b0;
         overVolt <= 1'b0;
         cyc(6);
         chk(gatesA, on4(4'b1001), "fault gone");
      end
   endtask

   task automatic t_wdog();
      @(posedge clk_sys);
      wdLongOpen <= 1'b1;
      cyc(3);
      chk(8'(forceOff), 8'h01, "hold set");
      chk(gatesA, 8'h00, "held a");
      chk(gatesB, 8'h00, "held b");
      wr(REG_CTRL_A, 8'h01);
      rdchk(REG_CTRL_A, 8'h01, "write in hold");
      rdchk(REG_STATUS, 8'h01 << STAT_FORCE_BIT, "status in hold");
      pulse_watchdog_trigger_bit();
      cyc(3);
      chk(8'(forceOff), 8'h01, "trigger too early");
      @(posedge clk_sys);
      wdLongOpen <= 1'b0;
      cyc(3);
      chk(8'(forceOff), 8'h01, "waits for trigger");
      chk(gatesA, 8'h00, "still held");
      pulse_watchdog_trigger_bit();
      cyc(3);
      chk(8'(forceOff), 8'h00, "hold released");
      chk(gatesA, on4(4'b0110), "drive after hold");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      {wrStrobe, rdStrobe, cpLow, overVolt, thermal, wdLongOpen, wdTrigValid} = '0;
      addr = '0;
      wrData = '0;
      dsShortA = 4'h0;
      dsShortB = 4'h0;
      pwmReq = 4'h0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      $display("reset and register test done");
      t_single();
      $display("single mode test done");
      t_dual();
      $display("dual mode test done");
      t_short();
      $display("short test done");
      t_fault();
      $display("fault test done");
      t_wdog();
      $display("watchdog test done");
      tally_and_finish();
   end
endmodule
